// ==== common/ckp_pkg.sv ====
// shared constants, types and command coding for the cke power-state link
package ckp_pkg;

    // ------------------------------------------------------------------
    // bus widths and field positions
    // ------------------------------------------------------------------
    localparam int BA_W        = 2;
    localparam int ADDR_W      = 14;
    localparam int NBANK       = 4;
    localparam int AP_BIT      = 10;   // auto/all precharge address bit
    localparam int RTT_LO_BIT  = 2;    // extended mode 1 termination bits
    localparam int RTT_HI_BIT  = 6;
    localparam int HOT_SR_BIT  = 7;    // extended mode 2 hot self refresh
    localparam logic [1:0] BA_EMR1 = 2'h1;
    localparam logic [1:0] BA_EMR2 = 2'h2;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 10;
    localparam int CKE_MIN_CLK    = 3;
    localparam int XSRD_CLK       = 200;
    localparam int T_XSNR_NS      = 138;
    localparam int T_REFI_NS      = 7800;
    localparam int T_REFI_HOT_NS  = 3900;
    localparam int BUSY_CLK       = 8;  // settle time after any operation but activate
    // least time rounds up, longest time rounds down
    localparam int XSNR_CLK =
        (T_XSNR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int REFI_CLK     = T_REFI_NS / CLK_PERIOD_NS;
    localparam int REFI_HOT_CLK = T_REFI_HOT_NS / CLK_PERIOD_NS;

    // ------------------------------------------------------------------
    // pin coding {cs_n, ras_n, cas_n, we_n}
    // ------------------------------------------------------------------
    localparam logic [3:0] PIN_DESEL = 4'hF;
    localparam logic [3:0] PIN_NOP   = 4'h7;
    localparam logic [3:0] PIN_ACT   = 4'h3;
    localparam logic [3:0] PIN_PRE   = 4'h2;
    localparam logic [3:0] PIN_REF   = 4'h1;
    localparam logic [3:0] PIN_MRS   = 4'h0;
    localparam logic [3:0] PIN_RD    = 4'h5;
    localparam logic [3:0] PIN_WR    = 4'h4;

    typedef enum logic [2:0] {
        CKP_OP_NOP, CKP_OP_ACT, CKP_OP_PRE, CKP_OP_REF,
        CKP_OP_MRS, CKP_OP_RD, CKP_OP_WR, CKP_OP_BAD
    } ckp_op_t;

    typedef enum logic [2:0] {
        CKP_MS_IDLE, CKP_MS_ACTIVE, CKP_MS_APD, CKP_MS_PPD, CKP_MS_SREF
    } ckp_mstate_t;

    typedef enum logic [1:0] {
        CKP_RTT_OFF, CKP_RTT_75, CKP_RTT_150, CKP_RTT_50
    } ckp_rtt_t;

    // deselect (cs_n high) decodes as nop whatever the other three show
    function automatic ckp_op_t ckp_decode(input logic [3:0] p);
        ckp_op_t r;
        r = CKP_OP_BAD;
        if (p[3]) begin
            r = CKP_OP_NOP;
        end else begin
            case (p)
                PIN_NOP: r = CKP_OP_NOP;
                PIN_ACT: r = CKP_OP_ACT;
                PIN_PRE: r = CKP_OP_PRE;
                PIN_REF: r = CKP_OP_REF;
                PIN_MRS: r = CKP_OP_MRS;
                PIN_RD:  r = CKP_OP_RD;
                PIN_WR:  r = CKP_OP_WR;
                default: r = CKP_OP_BAD;
            endcase
        end
        return r;
    endfunction : ckp_decode

    function automatic logic [3:0] ckp_encode(input ckp_op_t op);
        logic [3:0] r;
        r = PIN_DESEL;
        case (op)
            CKP_OP_ACT: r = PIN_ACT;
            CKP_OP_PRE: r = PIN_PRE;
            CKP_OP_REF: r = PIN_REF;
            CKP_OP_MRS: r = PIN_MRS;
            CKP_OP_RD:  r = PIN_RD;
            CKP_OP_WR:  r = PIN_WR;
            default:    r = PIN_DESEL;
        endcase
        return r;
    endfunction : ckp_encode

endpackage : ckp_pkg

// ==== common/ckp_if.sv ====
// command, clock-enable and termination pins between controller and memory
`timescale 1ns/10ps
`default_nettype none
interface ckp_if;
    logic        cke;
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic        odt;
    logic [1:0]  ba;
    logic [13:0] addr;

    modport ctl (
        output cke, cs_n, ras_n, cas_n, we_n, odt, ba, addr
    );
    modport mem (
        input  cke, cs_n, ras_n, cas_n, we_n, odt, ba, addr
    );
endinterface : ckp_if
`default_nettype wire

// ==== hw/ckp_mem_end.sv ====
// memory end: cke power-state tracking, bank state and termination select
`timescale 1ns/10ps
`default_nettype none
module ckp_mem_end (
    input  wire logic                ref_clk,
    input  wire logic                rst_b,
    ckp_if.mem                       pins,
    output var  ckp_pkg::ckp_mstate_t state_q,
    output var  ckp_pkg::ckp_rtt_t   rtt_q,
    output logic                     term_on_q,
    output logic                     hot_sr_q,
    output logic [3:0]               bank_open_q,
    output logic                     illegal_q
);
    // ------------------------------------------------------------------
    // edge view: level now against level one edge ago
    // ------------------------------------------------------------------
    logic                 cke_prev_q;
    logic [1:0]           run_q;
    logic [1:0]           run_d;
    ckp_pkg::ckp_op_t     op;
    ckp_pkg::ckp_mstate_t state_d;
    logic [3:0]           bank_d;
    logic                 bad_d;
    logic                 rtt_lo_q;
    logic                 rtt_hi_q;

    wire both_hi  = pins.cke & cke_prev_q;
    wire cke_rise = pins.cke & ~cke_prev_q;
    wire cke_fall = ~pins.cke & cke_prev_q;
    wire quiet    = (op == ckp_pkg::CKP_OP_NOP);
    wire any_open = |bank_open_q;
    wire short_run = (cke_rise | cke_fall)
                   & (run_q < 2'(ckp_pkg::CKE_MIN_CLK));
    wire mrs_hit  = both_hi & (op == ckp_pkg::CKP_OP_MRS);
    wire [1:0] ba = pins.ba;

    assign op = ckp_pkg::ckp_decode(
        {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n});

    // commands only count with cke high on both edges
    always_comb begin
        bank_d = bank_open_q;
        if (both_hi) begin
            for (int b = 0; b < ckp_pkg::NBANK; b++) begin
                if (ba == 2'(b)) begin
                    if (op == ckp_pkg::CKP_OP_ACT) begin
                        bank_d[b] = 1'b1;
                    end
                    if ((op == ckp_pkg::CKP_OP_RD
                         || op == ckp_pkg::CKP_OP_WR)
                        && pins.addr[ckp_pkg::AP_BIT]) begin
                        bank_d[b] = 1'b0;
                    end
                end
                if (op == ckp_pkg::CKP_OP_PRE
                    && (ba == 2'(b) || pins.addr[ckp_pkg::AP_BIT])) begin
                    bank_d[b] = 1'b0;
                end
            end
        end
    end

    // power-state walk; odt takes no part in it
    always_comb begin
        state_d = state_q;
        bad_d   = short_run;
        case (state_q)
            ckp_pkg::CKP_MS_APD, ckp_pkg::CKP_MS_PPD: begin
                // other pins ignored while cke stays low
                if (cke_rise) begin
                    bad_d   = bad_d | ~quiet;
                    state_d = (state_q == ckp_pkg::CKP_MS_APD)
                            ? ckp_pkg::CKP_MS_ACTIVE
                            : ckp_pkg::CKP_MS_IDLE;
                end
            end
            ckp_pkg::CKP_MS_SREF: begin
                // exit rides on cke alone, the command is only checked
                if (cke_rise) begin
                    bad_d   = bad_d | ~quiet;
                    state_d = ckp_pkg::CKP_MS_IDLE;
                end
            end
            ckp_pkg::CKP_MS_IDLE, ckp_pkg::CKP_MS_ACTIVE: begin
                if (cke_fall && op == ckp_pkg::CKP_OP_REF) begin
                    // refused with a bank open: stay powered down
                    bad_d   = bad_d | any_open;
                    state_d = any_open ? ckp_pkg::CKP_MS_APD
                                       : ckp_pkg::CKP_MS_SREF;
                end else if (cke_fall) begin
                    bad_d   = bad_d | ~quiet;
                    state_d = any_open ? ckp_pkg::CKP_MS_APD
                                       : ckp_pkg::CKP_MS_PPD;
                end else if (both_hi) begin
                    bad_d   = bad_d | (op == ckp_pkg::CKP_OP_BAD)
                            | (op == ckp_pkg::CKP_OP_REF && any_open);
                    state_d = (|bank_d) ? ckp_pkg::CKP_MS_ACTIVE
                                        : ckp_pkg::CKP_MS_IDLE;
                end else begin
                    bad_d   = 1'b1;
                end
            end
            default: state_d = ckp_pkg::CKP_MS_IDLE;
        endcase
    end

    // run length of the sampled cke level, saturating
    assign run_d = (cke_rise | cke_fall) ? 2'h1
                 : (run_q == 2'h3) ? run_q : run_q + 2'h1;

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    // run starts saturated so the first rise out of reset is not flagged
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cke_prev_q  <= 1'b0;
            run_q       <= 2'h3;
            state_q     <= ckp_pkg::CKP_MS_PPD;
            bank_open_q <= 4'h0;
            illegal_q   <= 1'b0;
        end else begin
            cke_prev_q  <= pins.cke;
            run_q       <= run_d;
            state_q     <= state_d;
            bank_open_q <= bank_d;
            illegal_q   <= bad_d;
        end
    end

    // mode bits caught from extended mode register writes
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rtt_lo_q <= 1'b0;
            rtt_hi_q <= 1'b0;
            hot_sr_q <= 1'b0;
        end else if (mrs_hit && ba == ckp_pkg::BA_EMR1) begin
            rtt_lo_q <= pins.addr[ckp_pkg::RTT_LO_BIT];
            rtt_hi_q <= pins.addr[ckp_pkg::RTT_HI_BIT];
        end else if (mrs_hit && ba == ckp_pkg::BA_EMR2) begin
            hot_sr_q <= pins.addr[ckp_pkg::HOT_SR_BIT];
        end
    end

    // termination value and enable; never on in self refresh
    wire ckp_pkg::ckp_rtt_t rtt_d = ckp_pkg::ckp_rtt_t'(
        {rtt_hi_q, rtt_lo_q});
    wire term_d = pins.odt & (rtt_d != ckp_pkg::CKP_RTT_OFF)
                & (state_d != ckp_pkg::CKP_MS_SREF);
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rtt_q     <= ckp_pkg::CKP_RTT_OFF;
            term_on_q <= 1'b0;
        end else begin
            rtt_q     <= rtt_d;
            term_on_q <= term_d;
        end
    end

endmodule : ckp_mem_end
`default_nettype wire

// ==== hw/ckp_ctl_end.sv ====
// controller end: drives cke, commands and odt through power states
`timescale 1ns/10ps
`default_nettype none
module ckp_ctl_end (
    input  wire logic              ref_clk,
    input  wire logic              rst_b,
    ckp_if.ctl                     pins,
    input  wire logic              cmd_valid,
    input  wire ckp_pkg::ckp_op_t  cmd_op,
    input  wire logic [1:0]        cmd_ba,
    input  wire logic [13:0]       cmd_addr,
    output logic                   cmd_ready_q,
    output logic                   rd_ok_q,
    input  wire logic              pd_req,
    input  wire logic              sr_req,
    input  wire logic              hot,
    input  wire logic              ocd_cal,
    input  wire logic              odt_en,
    output logic                   in_pd_q,
    output logic                   in_sr_q
);
    // ------------------------------------------------------------------
    // state and counters
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {C_RUN, C_PD, C_SR, C_XSNR} ckp_cst_t;

    ckp_cst_t         st_q;
    ckp_cst_t         st_d;
    ckp_pkg::ckp_op_t op_d;
    logic             cke_q;
    logic             cke_d;
    logic [3:0]       pin_q;
    logic [1:0]       ba_q;
    logic [1:0]       ba_d;
    logic [13:0]      addr_q;
    logic [13:0]      addr_d;
    logic             odt_q;
    logic [1:0]       run_q;
    logic [3:0]       busy_q;
    logic [7:0]       xsnr_q;
    logic [7:0]       xsrd_q;
    logic [9:0]       ref_cnt_q;
    logic             ref_due_q;
    logic             a7_q;
    logic [3:0]       bank_q;
    logic [3:0]       bank_d;

    // ------------------------------------------------------------------
    // decisions
    // ------------------------------------------------------------------
    // user commands win over internal ones only when ready was shown
    wire take = (st_q == C_RUN) & cmd_valid & cmd_ready_q
              & (cmd_op != ckp_pkg::CKP_OP_RD | rd_ok_q)
              & (cmd_op != ckp_pkg::CKP_OP_BAD);
    wire run_ok   = (run_q >= 2'(ckp_pkg::CKE_MIN_CLK));
    wire quiet    = (busy_q == 4'h0);
    wire open_any = |bank_q;
    wire a7_stale = (a7_q != hot);
    wire want_ref = ref_due_q & quiet & ~take;
    wire want_sr  = sr_req & quiet & run_ok & ~ocd_cal
                  & ~take & ~ref_due_q;
    wire want_pd  = pd_req & quiet & run_ok & ~ocd_cal
                  & ~take & ~ref_due_q & ~sr_req;
    // refresh due pulls the memory out of power-down
    wire pd_exit  = (~pd_req | ref_due_q | ocd_cal) & run_ok;
    wire sr_exit  = (~sr_req | ocd_cal) & run_ok;
    wire is_ref   = (op_d == ckp_pkg::CKP_OP_REF);
    wire op_busy  = (op_d != ckp_pkg::CKP_OP_NOP)
                  & (op_d != ckp_pkg::CKP_OP_ACT);
    wire ref_wrap = (ref_cnt_q == 10'h0);
    wire [9:0] refi = hot ? 10'(ckp_pkg::REFI_HOT_CLK)
                          : 10'(ckp_pkg::REFI_CLK);

    // next command and cke; anything not chosen goes out as deselect
    always_comb begin
        st_d   = st_q;
        cke_d  = cke_q;
        op_d   = ckp_pkg::CKP_OP_NOP;
        ba_d   = 2'h0;
        addr_d = 14'h0;
        case (st_q)
            C_RUN: begin
                if (take) begin
                    op_d   = cmd_op;
                    ba_d   = cmd_ba;
                    addr_d = cmd_addr;
                end else if ((want_ref | want_sr) && open_any) begin
                    // close every bank before refresh or self refresh
                    op_d   = ckp_pkg::CKP_OP_PRE;
                    addr_d[ckp_pkg::AP_BIT] = 1'b1;
                end else if (want_ref) begin
                    op_d   = ckp_pkg::CKP_OP_REF;
                end else if (want_sr && a7_stale) begin
                    op_d   = ckp_pkg::CKP_OP_MRS;
                    ba_d   = ckp_pkg::BA_EMR2;
                    addr_d[ckp_pkg::HOT_SR_BIT] = hot;
                end else if (want_sr) begin
                    op_d   = ckp_pkg::CKP_OP_REF;
                    cke_d  = 1'b0;
                    st_d   = C_SR;
                end else if (want_pd) begin
                    cke_d  = 1'b0;
                    st_d   = C_PD;
                end
            end
            C_PD: begin
                if (pd_exit) begin
                    cke_d = 1'b1;
                    st_d  = C_RUN;
                end
            end
            C_SR: begin
                if (sr_exit) begin
                    cke_d = 1'b1;
                    st_d  = C_XSNR;
                end
            end
            C_XSNR: begin
                if (xsnr_q == 8'h0) begin
                    st_d = C_RUN;
                end
            end
            default: st_d = C_RUN;
        endcase
    end

    // bank book-keeping mirrors what the memory will record
    always_comb begin
        bank_d = bank_q;
        for (int b = 0; b < ckp_pkg::NBANK; b++) begin
            if (ba_d == 2'(b) && op_d == ckp_pkg::CKP_OP_ACT) begin
                bank_d[b] = 1'b1;
            end
            if ((ba_d == 2'(b) || addr_d[ckp_pkg::AP_BIT])
                && op_d == ckp_pkg::CKP_OP_PRE) begin
                bank_d[b] = 1'b0;
            end
            if (ba_d == 2'(b) && addr_d[ckp_pkg::AP_BIT]
                && (op_d == ckp_pkg::CKP_OP_RD
                    || op_d == ckp_pkg::CKP_OP_WR)) begin
                bank_d[b] = 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // pins and state
    // ------------------------------------------------------------------
    // cke starts low so the memory sits powered down out of reset
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q   <= C_PD;
            cke_q  <= 1'b0;
            pin_q  <= ckp_pkg::PIN_DESEL;
            ba_q   <= 2'h0;
            addr_q <= 14'h0;
            bank_q <= 4'h0;
        end else begin
            st_q   <= st_d;
            cke_q  <= cke_d;
            pin_q  <= ckp_pkg::ckp_encode(op_d);
            ba_q   <= ba_d;
            addr_q <= addr_d;
            bank_q <= bank_d;
        end
    end

    // odt held at a defined level in power-down, low in self refresh
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            odt_q <= 1'b0;
        end else begin
            odt_q <= odt_en & (st_d != C_SR);
        end
    end

    // cke run length: a change is only allowed at three or more
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            run_q <= 2'h0;
        end else if (cke_d != cke_q) begin
            run_q <= 2'h1;
        end else if (run_q != 2'h3) begin
            run_q <= run_q + 2'h1;
        end
    end

    // busy after each operation except activate keeps cke from dropping under it
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            busy_q <= 4'h0;
        end else if (op_busy) begin
            busy_q <= 4'(ckp_pkg::BUSY_CLK);
        end else if (busy_q != 4'h0) begin
            busy_q <= busy_q - 4'h1;
        end
    end

    // exit waits: deselects through xsnr, reads held through xsrd
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            xsnr_q <= 8'h0;
            xsrd_q <= 8'h0;
        end else if (st_q == C_SR && sr_exit) begin
            xsnr_q <= 8'(ckp_pkg::XSNR_CLK - 1);
            xsrd_q <= 8'(ckp_pkg::XSRD_CLK);
        end else begin
            if (xsnr_q != 8'h0) begin
                xsnr_q <= xsnr_q - 8'h1;
            end
            if (xsrd_q != 8'h0) begin
                xsrd_q <= xsrd_q - 8'h1;
            end
        end
    end

    // refresh interval timer; a new due beats a clear in one cycle
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ref_cnt_q <= 10'(ckp_pkg::REFI_CLK);
            ref_due_q <= 1'b0;
        end else if (st_q == C_SR || st_q == C_XSNR) begin
            // memory refreshes itself; restart the interval on exit
            ref_cnt_q <= refi;
            ref_due_q <= 1'b0;
        end else begin
            ref_cnt_q <= ref_wrap ? refi : ref_cnt_q - 10'h1;
            ref_due_q <= ref_wrap | (ref_due_q & ~is_ref);
        end
    end

    // mirror of the hot self refresh bit last written
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            a7_q <= 1'b0;
        end else if (op_d == ckp_pkg::CKP_OP_MRS
                     && ba_d == ckp_pkg::BA_EMR2) begin
            a7_q <= addr_d[ckp_pkg::HOT_SR_BIT];
        end
    end

    // status shown on the same edge as the pins that carry it
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cmd_ready_q <= 1'b0;
            rd_ok_q     <= 1'b1;
            in_pd_q     <= 1'b1;
            in_sr_q     <= 1'b0;
        end else begin
            cmd_ready_q <= (st_d == C_RUN) & ~sr_req & ~pd_req
                         & ~(ref_wrap | ref_due_q);
            rd_ok_q     <= (xsrd_q <= 8'h1)
                         & ~(st_q == C_SR && sr_exit);
            in_pd_q     <= (st_d == C_PD);
            in_sr_q     <= (st_d == C_SR);
        end
    end

    assign pins.cke   = cke_q;
    assign pins.cs_n  = pin_q[3];
    assign pins.ras_n = pin_q[2];
    assign pins.cas_n = pin_q[1];
    assign pins.we_n  = pin_q[0];
    assign pins.ba    = ba_q;
    assign pins.addr  = addr_q;
    assign pins.odt   = odt_q;

endmodule : ckp_ctl_end
`default_nettype wire

// ==== tb/ckp_pins_checker.sv ====
// assertions on the pins between the two ends
`timescale 1ns/10ps
`default_nettype none
module ckp_pins_checker (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic odt
);
    // ------------------------------------------------------------
    // helper state
    // ------------------------------------------------------------
    logic       sr_q;
    logic [7:0] hold_q;
    wire  [3:0] pin_w = {cs_n, ras_n, cas_n, we_n};
    wire        idle_w = cs_n || (pin_w == ckp_pkg::PIN_NOP);
    // refresh with cke low marks entry; the exit edge arms the read hold
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            sr_q   <= 1'h0;
            hold_q <= 8'h00;
        end else begin
            sr_q   <= cke ? 1'h0 : (sr_q || pin_w == ckp_pkg::PIN_REF);
            hold_q <= (sr_q && cke) ? 8'(ckp_pkg::XSRD_CLK - 1)
                    : hold_q - {7'h00, hold_q != 8'h00};
        end
    end
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);
    cke_high_min_a:
        assert property ($rose(cke) |=> cke [*2]) else $error("short high");
    cke_low_min_a:
        assert property ($fell(cke) |=> !cke [*2]) else $error("short low");
    exit_cmd_idle_a:
        assert property ($rose(cke) |-> idle_w) else $error("exit cmd");
    entry_cmd_a:
        assert property ($fell(cke) |-> idle_w || pin_w == ckp_pkg::PIN_REF)
        else $error("entry cmd");
    xsnr_quiet_a:
        assert property ($rose(cke) && sr_q |-> idle_w [*8] ##1 idle_w [*7])
        else $error("cmd in exit wait");
    read_hold_a:
        assert property (pin_w == ckp_pkg::PIN_RD |-> hold_q == 8'h00)
        else $error("early read");
    low_quiet_a:
        assert property (!cke && !$past(cke) |-> cs_n) else $error("cmd low");
    sr_odt_off_a:
        assert property (sr_q && !cke |-> !odt) else $error("odt in sr");
endmodule : ckp_pins_checker
`default_nettype wire

// ==== tb/tb_sdram_cke_power_state_control.sv ====
// self-checking bench joining controller end and memory end
`timescale 1ns/10ps
`default_nettype none
module tb_sdram_cke_power_state_control;
    logic                 ref_clk, rst_b, vld, pd, sr, hot, rdy, rdok;
    logic                 in_pd, in_sr, term, hot_sr, bad, ocd, odt_on;
    logic [1:0]           ba;
    logic [13:0]          addr;
    logic [3:0]           banks;
    ckp_pkg::ckp_op_t     op;
    ckp_pkg::ckp_mstate_t st;
    ckp_pkg::ckp_rtt_t    rtt;
    int                   error_cnt, comparisons, n;
    ckp_if                pins ();
    ckp_ctl_end ckp_ctl_end_i (.ref_clk(ref_clk), .rst_b(rst_b),
        .pins(pins.ctl), .cmd_valid(vld), .cmd_op(op), .cmd_ba(ba),
        .cmd_addr(addr), .cmd_ready_q(rdy), .rd_ok_q(rdok), .pd_req(pd),
        .sr_req(sr), .hot(hot), .ocd_cal(ocd), .odt_en(odt_on),
        .in_pd_q(in_pd), .in_sr_q(in_sr));
    ckp_mem_end ckp_mem_end_i (.ref_clk(ref_clk), .rst_b(rst_b),
        .pins(pins.mem), .state_q(st), .rtt_q(rtt), .term_on_q(term),
        .hot_sr_q(hot_sr), .bank_open_q(banks), .illegal_q(bad));
    ckp_pins_checker ckp_pins_checker_i (.ref_clk(ref_clk), .rst_b(rst_b),
        .cke(pins.cke), .cs_n(pins.cs_n), .ras_n(pins.ras_n),
        .cas_n(pins.cas_n), .we_n(pins.we_n), .odt(pins.odt));
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task end_of_test(input bit hung);
        error_cnt += hung;
        $display("checks %0d errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_of_test
    // hold valid until ready is seen, so the command is taken once
    task issue(input ckp_pkg::ckp_op_t o, input logic [13:0] a);
        op   = o;
        addr = a;
        vld  = 1'h1;
        // a read is only taken once reads are allowed again
        for (n = 0; n < 999; n++) begin
            if (rdy && (rdok || o != ckp_pkg::CKP_OP_RD)) break;
            @(negedge ref_clk);
        end
        if (n == 999) end_of_test(1);
        @(negedge ref_clk);
        vld = 1'h0;
    endtask : issue
    task t_rtt();
        for (int k = 0; k < 4; k++) begin
            ba = ckp_pkg::BA_EMR1;
            issue(ckp_pkg::CKP_OP_MRS, {7'h00, k[1], 3'h0, k[0], 2'h0});
            repeat (3) @(negedge ref_clk);
            chk(rtt, 16'(k));
            chk(term, k != 0);
        end
        $display("t_rtt done");
    endtask : t_rtt
    task t_pd();
        ba = 2'h1;
        issue(ckp_pkg::CKP_OP_ACT, 14'h0010);
        pd = 1'h1;
        for (n = 0; !in_pd && n < 999; n++) @(negedge ref_clk);
        if (n == 999) end_of_test(1);
        // memory sees the low cke one edge after the status flag
        @(negedge ref_clk);
        chk(st, ckp_pkg::CKP_MS_APD);
        chk(pins.odt, odt_on);
        repeat (4) @(negedge ref_clk);
        pd = 1'h0;
        repeat (3) @(negedge ref_clk);
        chk(in_pd, 1'h0);
        chk(st, ckp_pkg::CKP_MS_ACTIVE);
        $display("t_pd done");
    endtask : t_pd
    // banks open and hot bit stale: both must be fixed before entry
    task t_sr();
        hot = 1'h1;
        sr  = 1'h1;
        for (n = 0; !in_sr && n < 999; n++) @(negedge ref_clk);
        if (n == 999) end_of_test(1);
        repeat (2) @(negedge ref_clk);
        chk(st, ckp_pkg::CKP_MS_SREF);
        chk({banks, hot_sr, term}, 6'h02);
        sr = 1'h0;
        for (n = 0; rdok && n < 99; n++) @(negedge ref_clk);
        if (n == 99) end_of_test(1);
        for (n = 0; !rdok && n < 999; n++) @(negedge ref_clk);
        if (n == 999) end_of_test(1);
        chk(n > 198 && n < 999, 1'h1);
        // first read after the exit wait, watched by the read hold check
        issue(ckp_pkg::CKP_OP_ACT, 14'h0010);
        @(negedge ref_clk);
        issue(ckp_pkg::CKP_OP_RD, 14'h0000);
        $display("t_sr done");
    endtask : t_sr
    // calibration keeps cke up; a due refresh cuts power-down short
    task t_ocd();
        ocd = 1'h1;
        pd  = 1'h1;
        repeat (9) @(negedge ref_clk);
        chk(pins.cke, 1'h1);
        odt_on = 1'h0;
        repeat (2) @(negedge ref_clk);
        chk({pins.odt, term}, 2'h0);
        ocd    = 1'h0;
        odt_on = 1'h1;
        for (n = 0; !in_pd && n < 99; n++) @(negedge ref_clk);
        if (n == 99) end_of_test(1);
        for (n = 0; in_pd && n < 999; n++) @(negedge ref_clk);
        if (n == 999) end_of_test(1);
        for (n = 0; !in_pd && n < 99; n++) @(negedge ref_clk);
        if (n == 99) end_of_test(1);
        @(negedge ref_clk);
        chk({banks, st}, {4'h0, ckp_pkg::CKP_MS_PPD});
        pd = 1'h0;
        $display("t_ocd done");
    endtask : t_ocd
    // clock, reset, checks on the memory's fault flag, then the sequence
    initial begin
        ref_clk = 1'h0;
        forever #5 ref_clk = ~ref_clk;
    end
    always @(negedge ref_clk) if (rst_b) chk(bad, 1'h0);
    initial begin
        {rst_b, vld, pd, sr, hot, ocd, ba, addr} = '0;
        odt_on = 1'h1;
        op = ckp_pkg::CKP_OP_NOP;
        repeat (3) @(negedge ref_clk);
        rst_b = 1'h1;
        t_rtt();
        t_pd();
        t_sr();
        t_ocd();
        end_of_test(0);
    end
endmodule : tb_sdram_cke_power_state_control
`default_nettype wire
